// ===== rdc_pkg.sv
/*
 rdc_pkg: opcodes, field positions, default dummy counts, decode types
 and the command decode function of the read dummy-cycle select block.
 assumes: 8-bit opcodes, 3- or 4-byte addressing.
*/
`default_nettype none
package rdc_pkg;

  // read opcodes
  localparam logic [7:0] OP_FAST_RD = 8'h0b;
  localparam logic [7:0] OP_FAST_RD4 = 8'h0c;
  localparam logic [7:0] OP_FAST_DTR = 8'h0d;
  localparam logic [7:0] OP_FAST_DTR4 = 8'h0e;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_DUAL_OUT4 = 8'h3c;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_DUAL_IO4 = 8'hbc;
  localparam logic [7:0] OP_DUAL_IO_DTR = 8'hbd;
  localparam logic [7:0] OP_DUAL_IO_DTR4 = 8'hbe;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_QUAD_OUT4 = 8'h6c;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_QUAD_IO4 = 8'hec;
  localparam logic [7:0] OP_QUAD_IO_DTR = 8'hed;
  localparam logic [7:0] OP_QUAD_IO_DTR4 = 8'hee;
  // unique_id_read and info_row_read opcodes: arbitrary values
  localparam logic [7:0] OP_UNIQUE_ID_READ = 8'h71;
  localparam logic [7:0] OP_INFO_ROW_READ = 8'h72;
  // set_read_params_persistent / set_read_params_volatile
  localparam logic [7:0] OP_SET_PARAMS_PERSIST = 8'h65;
  localparam logic [7:0] OP_SET_PARAMS_VOL_A = 8'hc0;
  localparam logic [7:0] OP_SET_PARAMS_VOL_B = 8'h63;

  // read parameter register
  localparam int DUMMY_LSB = 3;
  localparam int DUMMY_MSB = 6;
  localparam logic [7:0] PARAM_RESET = 8'h00;
  localparam logic [3:0] DUMMY_USE_DEFAULT = 4'h0;

  // default dummy counts
  localparam logic [3:0] DEF_FAST_SPI = 4'h8;
  localparam logic [3:0] DEF_FAST_QPI = 4'h6;
  localparam logic [3:0] DEF_DUAL_OUT = 4'h8;
  localparam logic [3:0] DEF_DUAL_IO = 4'h4;
  localparam logic [3:0] DEF_QUAD_OUT = 4'h8;
  localparam logic [3:0] DEF_QUAD_IO = 4'h6;

  // frame phase lengths in clocks
  localparam logic [5:0] ADDR_BITS_3B = 6'h18;
  localparam logic [5:0] ADDR_BITS_4B = 6'h20;
  localparam logic [5:0] MODE_CLK_DUAL = 6'h04;
  localparam logic [5:0] MODE_CLK_QUAD = 6'h02;
  localparam logic [5:0] BYTE_LAST_SPI = 6'h07;
  localparam logic [5:0] BYTE_LAST_QPI = 6'h01;

  typedef enum logic [2:0] {
    CLS_NONE, CLS_FAST, CLS_DUAL_OUT, CLS_DUAL_IO, CLS_QUAD_OUT, CLS_QUAD_IO, CLS_SETP
  } rdc_cls_e;

  typedef struct packed {
    rdc_cls_e cls;
    logic dtr;
    logic wide;
    logic persist;
  } rdc_dec_s;

  function automatic rdc_dec_s rdc_decode(input logic [7:0] op, input logic qpi);
    rdc_dec_s d;
    d = '{cls: CLS_NONE, dtr: 1'b0, wide: 1'b0, persist: 1'b0};
    case (op)
      OP_FAST_RD, OP_FAST_RD4, OP_UNIQUE_ID_READ, OP_INFO_ROW_READ: d.cls = CLS_FAST;
      OP_FAST_DTR, OP_FAST_DTR4: begin
        d.cls = CLS_FAST;
        d.dtr = 1'b1;
      end
      OP_DUAL_OUT, OP_DUAL_OUT4: d.cls = qpi ? CLS_NONE : CLS_DUAL_OUT;
      OP_DUAL_IO, OP_DUAL_IO4: d.cls = qpi ? CLS_NONE : CLS_DUAL_IO;
      OP_DUAL_IO_DTR, OP_DUAL_IO_DTR4: begin
        d.cls = qpi ? CLS_NONE : CLS_DUAL_IO;
        d.dtr = 1'b1;
      end
      OP_QUAD_OUT, OP_QUAD_OUT4: d.cls = qpi ? CLS_NONE : CLS_QUAD_OUT;
      OP_QUAD_IO, OP_QUAD_IO4: d.cls = CLS_QUAD_IO;
      OP_QUAD_IO_DTR, OP_QUAD_IO_DTR4: begin
        d.cls = CLS_QUAD_IO;
        d.dtr = 1'b1;
      end
      OP_SET_PARAMS_PERSIST: begin
        d.cls = CLS_SETP;
        d.persist = 1'b1;
      end
      OP_SET_PARAMS_VOL_A, OP_SET_PARAMS_VOL_B: d.cls = CLS_SETP;
      default: d.cls = CLS_NONE;
    endcase
    case (op)
      OP_FAST_RD4, OP_FAST_DTR4, OP_DUAL_OUT4, OP_DUAL_IO4,
      OP_DUAL_IO_DTR4, OP_QUAD_OUT4, OP_QUAD_IO4, OP_QUAD_IO_DTR4: d.wide = 1'b1;
      default: d.wide = 1'b0;
    endcase
    return d;
  endfunction : rdc_decode

endpackage : rdc_pkg
`default_nettype wire

// ===== rdc_dummy_if.sv
/*
 rdc_dummy_if: link-clock signals between the frame engine and the
 dummy counter. assumes both ends run on the host serial clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface rdc_dummy_if;
  import rdc_pkg::*;
  logic load;
  rdc_cls_e cls;
  logic qpi;
  logic [3:0] field;
  logic [3:0] count;
  logic last;
  modport ctl (output load, output cls, output qpi, output field, input count, input last);
  modport ctr (input load, input cls, input qpi, input field, output count, output last);
endinterface : rdc_dummy_if
`default_nettype wire

// ===== rdc_dummy_ctr.sv
/*
 rdc_dummy_ctr: resolves the dummy count of a read command and counts it
 down on the serial clock. assumes load comes on the last address or
 mode clock, and that the frame engine watches last only in its dummy phase.
*/
`timescale 1ns/1ps
`default_nettype none
module rdc_dummy_ctr
  import rdc_pkg::*;
(
  input wire logic sclk, // host serial clock
  input wire logic lrst_b, // frame reset, active low
  rdc_dummy_if.ctr dif // counter side
);

  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] sel_count;

  function automatic logic [3:0] default_dummy(input rdc_cls_e c, input logic q);
    case (c)
      CLS_FAST: return q ? DEF_FAST_QPI : DEF_FAST_SPI;
      CLS_DUAL_OUT: return DEF_DUAL_OUT;
      CLS_DUAL_IO: return DEF_DUAL_IO;
      CLS_QUAD_OUT: return DEF_QUAD_OUT;
      CLS_QUAD_IO: return DEF_QUAD_IO;
      default: return DEF_FAST_SPI;
    endcase
  endfunction : default_dummy

  // zero field means per-command default
  assign sel_count = (dif.field == DUMMY_USE_DEFAULT) ? default_dummy(dif.cls, dif.qpi)
                                                      : dif.field;

  always_comb begin
    cnt_next = cnt_reg;
    if (dif.load) begin
      cnt_next = sel_count;
    end else if (cnt_reg != 4'h0) begin
      cnt_next = cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge sclk or negedge lrst_b) begin
    if (!lrst_b) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign dif.count = cnt_reg;
  assign dif.last = (cnt_reg == 4'h1);

endmodule : rdc_dummy_ctr
`default_nettype wire

// ===== rdc_read_dummy_sel.sv
/*
 rdc_read_dummy_sel: read dummy-cycle selection of a serial flash.
 holds the persistent and volatile read parameter copies on mclk, and on
 the host serial clock walks each read frame through opcode, address, mode
 (I/O reads only), dummy and data phases. assumes the host owns sclk and cs_b, sclk stands
 still outside frames, and read data arrives on rd_byte in the sclk domain.
*/
// Contract
// - nonzero dummy field N gives exactly N dummy clocks before read data
// - zero dummy field selects a per-command default count
// - default fast, unique-id and info-row read: 8 clocks SPI, 6 QPI
// - default dual-output read: 8 clocks, no double-rate form
// - default dual I/O read, single and double rate: 4 clocks
// - default quad-output read: 8 clocks, no double-rate form
// - default quad I/O read, single and double rate: 6 clocks
// - dual I/O double-rate read only in SPI mode
// - dummy field is read parameter bits 6 to 3
// - 65h writes persistent copy, C0h or 63h volatile copy
// - volatile copy loaded from persistent copy at power-up
`timescale 1ns/1ps
`default_nettype none
module rdc_read_dummy_sel
  import rdc_pkg::*;
(
  input wire logic mclk, // core clock
  input wire logic rst_b, // chip reset, async, active low
  input wire logic qpi_mode, // device in QPI mode, mclk domain
  output logic [7:0] nv_params, // persistent read parameters
  output logic [7:0] vol_params, // active read parameters
  input wire logic sclk, // host serial clock
  input wire logic cs_b, // host chip select, active low
  input wire logic [3:0] io_in, // data lines in
  output logic [3:0] io_out, // data lines out
  output logic [3:0] io_oe, // data line drive enables
  input wire logic [7:0] rd_byte, // next read byte, sclk domain
  output logic rd_byte_take // rd_byte consumed, one sclk
);

  typedef enum logic [2:0] {
    ST_OPC = 3'b000,
    ST_ADDR = 3'b001,
    ST_MODE = 3'b011,
    ST_DUMMY = 3'b010,
    ST_DATA = 3'b110,
    ST_PARAM = 3'b111,
    ST_IGN = 3'b101
  } rdc_state_e;

  // ---------------- mclk domain ----------------
  logic rs1_reg;
  logic rst_sync_b;
  logic qpi_reg;
  logic boot_reg;
  logic [7:0] nv_reg;
  logic [7:0] vol_reg;
  logic pt_s1_reg;
  logic pt_s2_reg;
  logic pt_s3_reg;
  logic pt_edge;
  logic [4:0] cfg_now;
  logic [4:0] cfg_held_reg;
  logic cfg_tgl_reg;

  // ---------------- sclk domain ----------------
  logic link_rst_b;
  logic cfg_s1_reg;
  logic cfg_s2_reg;
  logic cfg_s3_reg;
  logic l_qpi_reg;
  logic [3:0] l_field_reg;
  logic par_tgl_reg;
  logic par_persist_reg;
  logic [7:0] par_data_reg;
  rdc_state_e st_reg;
  rdc_state_e st_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [5:0] bcnt_reg;
  logic [5:0] ph_cnt_reg;
  rdc_dec_s dec_reg;
  rdc_dec_s dec_now;
  logic op_done;
  logic ph_zero;
  logic load_ctr;
  logic [1:0] lines_reg;
  logic [7:0] dsh_reg;
  logic [2:0] dcnt_reg;
  logic byte_load;
  logic take_reg;
  logic [3:0] oe_mask;

  rdc_dummy_if dif ();

  function automatic logic [5:0] addr_clks(input rdc_dec_s d, input logic q);
    logic [5:0] n;
    n = d.wide ? ADDR_BITS_4B : ADDR_BITS_3B;
    case (d.cls)
      CLS_FAST: n = q ? (n >> 2) : n;
      CLS_DUAL_IO: n = n >> 1;
      CLS_QUAD_IO: n = n >> 2;
      default: n = n;
    endcase
    return d.dtr ? (n >> 1) : n;
  endfunction : addr_clks

  function automatic logic [5:0] mode_clks(input rdc_dec_s d);
    logic [5:0] n;
    case (d.cls)
      CLS_DUAL_IO: n = MODE_CLK_DUAL;
      CLS_QUAD_IO: n = MODE_CLK_QUAD;
      default: n = 6'h00;
    endcase
    return d.dtr ? (n >> 1) : n;
  endfunction : mode_clks

  // 0: one line, 1: two lines, 2: four lines
  function automatic logic [1:0] data_lines(input rdc_dec_s d, input logic q);
    case (d.cls)
      CLS_FAST: return q ? 2'h2 : 2'h0;
      CLS_DUAL_OUT, CLS_DUAL_IO: return 2'h1;
      CLS_QUAD_OUT, CLS_QUAD_IO: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction : data_lines

  // reset release through two flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rs1_reg <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rst_sync_b <= rs1_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      qpi_reg <= 1'b0;
    end else begin
      qpi_reg <= qpi_mode;
    end
  end

  // parameter write toggle from the link
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pt_s1_reg <= 1'b0;
      pt_s2_reg <= 1'b0;
      pt_s3_reg <= 1'b0;
    end else begin
      pt_s1_reg <= par_tgl_reg;
      pt_s2_reg <= pt_s1_reg;
      pt_s3_reg <= pt_s2_reg;
    end
  end
  assign pt_edge = pt_s2_reg ^ pt_s3_reg;

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      nv_reg <= PARAM_RESET;
    end else if (pt_edge && par_persist_reg) begin
      nv_reg <= par_data_reg;
    end
  end

  // power-up copy of persistent into volatile
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      boot_reg <= 1'b1;
      vol_reg <= PARAM_RESET;
    end else begin
      boot_reg <= 1'b0;
      if (boot_reg) begin
        vol_reg <= nv_reg;
      end else if (pt_edge && !par_persist_reg) begin
        vol_reg <= par_data_reg;
      end
    end
  end

  // config word held stable, toggle announces change
  assign cfg_now = {qpi_reg, vol_reg[DUMMY_MSB:DUMMY_LSB]};
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cfg_held_reg <= 5'h00;
      cfg_tgl_reg <= 1'b0;
    end else if (cfg_now != cfg_held_reg) begin
      cfg_held_reg <= cfg_now;
      cfg_tgl_reg <= ~cfg_tgl_reg;
    end
  end

  assign nv_params = nv_reg;
  assign vol_params = vol_reg;

  // frame logic is cleared whenever chip select is high
  assign link_rst_b = rst_sync_b & ~cs_b;

  // config capture, survives between frames
  always_ff @(posedge sclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cfg_s1_reg <= 1'b0;
      cfg_s2_reg <= 1'b0;
      cfg_s3_reg <= 1'b0;
      l_qpi_reg <= 1'b0;
      l_field_reg <= 4'h0;
    end else begin
      cfg_s1_reg <= cfg_tgl_reg;
      cfg_s2_reg <= cfg_s1_reg;
      cfg_s3_reg <= cfg_s2_reg;
      if (cfg_s2_reg != cfg_s3_reg) begin
        l_qpi_reg <= cfg_held_reg[4];
        l_field_reg <= cfg_held_reg[3:0];
      end
    end
  end

  // serial byte shifter for opcode and parameter byte
  assign sh_next = l_qpi_reg ? {sh_reg[3:0], io_in} : {sh_reg[6:0], io_in[0]};
  assign op_done = (st_reg == ST_OPC) && (bcnt_reg == (l_qpi_reg ? BYTE_LAST_QPI
                                                                 : BYTE_LAST_SPI));
  assign dec_now = rdc_decode(sh_next, l_qpi_reg);
  assign ph_zero = (ph_cnt_reg == 6'h00);

  always_comb begin
    st_next = st_reg;
    load_ctr = 1'b0;
    case (st_reg)
      ST_OPC: begin
        if (op_done) begin
          case (dec_now.cls)
            CLS_NONE: st_next = ST_IGN;
            CLS_SETP: st_next = ST_PARAM;
            default: st_next = ST_ADDR;
          endcase
        end
      end
      ST_ADDR: begin
        if (ph_zero) begin
          if (mode_clks(dec_reg) != 6'h00) begin
            st_next = ST_MODE;
          end else begin
            st_next = ST_DUMMY;
            load_ctr = 1'b1;
          end
        end
      end
      ST_MODE: begin
        if (ph_zero) begin
          st_next = ST_DUMMY;
          load_ctr = 1'b1;
        end
      end
      ST_DUMMY: begin
        if (dif.last) begin
          st_next = ST_DATA;
        end
      end
      ST_PARAM: begin
        if (ph_zero) begin
          st_next = ST_IGN;
        end
      end
      ST_DATA, ST_IGN: st_next = st_reg;
      default: st_next = ST_IGN;
    endcase
  end

  always_ff @(posedge sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      st_reg <= ST_OPC;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      sh_reg <= 8'h00;
      bcnt_reg <= 6'h00;
      dec_reg <= '{cls: CLS_NONE, dtr: 1'b0, wide: 1'b0, persist: 1'b0};
    end else begin
      if (st_reg == ST_OPC || st_reg == ST_PARAM) begin
        sh_reg <= sh_next;
      end
      if (st_reg == ST_OPC) begin
        bcnt_reg <= bcnt_reg + 6'h01;
      end
      if (op_done) begin
        dec_reg <= dec_now;
      end
    end
  end

  // phase length counter
  always_ff @(posedge sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      ph_cnt_reg <= 6'h00;
    end else if (op_done) begin
      if (dec_now.cls == CLS_SETP) begin
        ph_cnt_reg <= l_qpi_reg ? BYTE_LAST_QPI : BYTE_LAST_SPI;
      end else begin
        ph_cnt_reg <= addr_clks(dec_now, l_qpi_reg) - 6'h01;
      end
    end else if (st_reg == ST_ADDR && ph_zero) begin
      ph_cnt_reg <= mode_clks(dec_reg) - 6'h01;
    end else if (!ph_zero) begin
      ph_cnt_reg <= ph_cnt_reg - 6'h01;
    end
  end

  // parameter byte handed to mclk, held until the next write
  always_ff @(posedge sclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      par_tgl_reg <= 1'b0;
      par_persist_reg <= 1'b0;
      par_data_reg <= PARAM_RESET;
    end else if (st_reg == ST_PARAM && ph_zero && !cs_b) begin
      par_data_reg <= sh_next;
      par_persist_reg <= dec_reg.persist;
      par_tgl_reg <= ~par_tgl_reg;
    end
  end

  // dummy counter
  assign dif.load = load_ctr;
  assign dif.cls = dec_reg.cls;
  assign dif.qpi = l_qpi_reg;
  assign dif.field = l_field_reg;

  rdc_dummy_ctr u_dummy (
    .sclk(sclk),
    .lrst_b(link_rst_b),
    .dif(dif)
  );

  // read data shifter
  assign byte_load = ((st_reg == ST_DUMMY) && dif.last) ||
                     ((st_reg == ST_DATA) && (dcnt_reg == 3'h0));

  always_ff @(posedge sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      lines_reg <= 2'h0;
      dsh_reg <= 8'h00;
      dcnt_reg <= 3'h0;
      take_reg <= 1'b0;
    end else begin
      take_reg <= byte_load;
      if (op_done) begin
        lines_reg <= data_lines(dec_now, l_qpi_reg);
      end
      if (byte_load) begin
        dsh_reg <= rd_byte;
        case (lines_reg)
          2'h0: dcnt_reg <= 3'h7;
          2'h1: dcnt_reg <= 3'h3;
          default: dcnt_reg <= 3'h1;
        endcase
      end else if (st_reg == ST_DATA) begin
        dcnt_reg <= dcnt_reg - 3'h1;
        case (lines_reg)
          2'h0: dsh_reg <= {dsh_reg[6:0], 1'b0};
          2'h1: dsh_reg <= {dsh_reg[5:0], 2'b00};
          default: dsh_reg <= {dsh_reg[3:0], 4'h0};
        endcase
      end
    end
  end

  always_comb begin
    case (lines_reg)
      2'h0: begin
        io_out = {2'b00, dsh_reg[7], 1'b0};
        oe_mask = 4'h2;
      end
      2'h1: begin
        io_out = {2'b00, dsh_reg[7:6]};
        oe_mask = 4'h3;
      end
      default: begin
        io_out = dsh_reg[7:4];
        oe_mask = 4'hf;
      end
    endcase
  end

  // lines stay released through address, mode and dummy phases
  assign io_oe = (st_reg == ST_DATA) ? oe_mask : 4'h0;
  assign rd_byte_take = take_reg;

endmodule : rdc_read_dummy_sel
`default_nettype wire

// ===== rdc_read_dummy_monitor.sv
/*
 rdc_read_dummy_monitor: port-level checks of the read dummy-cycle block.
 assumes sclk stands still while cs_b is high.
*/
`timescale 1ns/1ps
`default_nettype none
module rdc_read_dummy_monitor (
  input wire logic mclk, // core clock
  input wire logic rst_b, // chip reset
  input wire logic qpi_mode, // qpi mode
  input wire logic [7:0] nv_params, // persistent params
  input wire logic [7:0] vol_params, // active params
  input wire logic sclk, // serial clock
  input wire logic cs_b, // chip select
  input wire logic [3:0] io_in, // lines in
  input wire logic [3:0] io_out, // lines out
  input wire logic [3:0] io_oe, // drive enables
  input wire logic [7:0] rd_byte, // read source
  input wire logic rd_byte_take // source advance
);
  logic [5:0] edge_cnt;
  // sclk edges seen in the current frame
  always_ff @(posedge sclk or posedge cs_b) begin
    if (cs_b) begin
      edge_cnt <= 6'h00;
    end else if (edge_cnt != 6'h3f) begin
      edge_cnt <= edge_cnt + 6'h01;
    end
  end
  a_reset_clears: assert property (@(posedge mclk) !rst_b |-> nv_params == 8'h00 && vol_params == 8'h00 && io_oe == 4'h0)
    else $error("state not cleared in reset");
  a_idle_no_drive: assert property (@(posedge mclk) disable iff (!rst_b) cs_b |-> io_oe == 4'h0)
    else $error("lines driven outside a frame");
  a_oe_stands: assert property (@(posedge mclk) disable iff (!rst_b) (!cs_b && io_oe != 4'h0) ##1 !cs_b |-> $stable(io_oe))
    else $error("drive enable moved within a frame");
  a_oe_width: assert property (@(posedge sclk) disable iff (cs_b) io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal drive enable pattern");
  a_oe_not_early: assert property (@(posedge sclk) disable iff (cs_b) io_oe != 4'h0 |-> edge_cnt >= 6'h06)
    else $error("data driven too early");
  a_take_spaced: assert property (@(posedge sclk) disable iff (cs_b) rd_byte_take |=> !rd_byte_take)
    else $error("take pulse longer than one clock");
  a_take_in_data: assert property (@(posedge sclk) disable iff (cs_b) rd_byte_take |-> io_oe != 4'h0)
    else $error("take outside data phase");
  a_first_bit_one: assert property (@(posedge sclk) disable iff (cs_b) $rose(io_oe == 4'h2) |-> io_out[1] == $past(rd_byte[7]))
    else $error("first single-line bit wrong");
  a_first_bits_two: assert property (@(posedge sclk) disable iff (cs_b) $rose(io_oe == 4'h3) |-> io_out[1:0] == $past(rd_byte[7:6]))
    else $error("first dual-line bits wrong");
  a_first_nib_four: assert property (@(posedge sclk) disable iff (cs_b) $rose(io_oe == 4'hf) |-> io_out == $past(rd_byte[7:4]))
    else $error("first quad-line nibble wrong");
  c_one_line: cover property (@(posedge sclk) $rose(io_oe == 4'h2));
  c_four_line: cover property (@(posedge sclk) $rose(io_oe == 4'hf));
  c_vol_write: cover property (@(posedge mclk) $changed(vol_params));
endmodule : rdc_read_dummy_monitor
bind rdc_read_dummy_sel rdc_read_dummy_monitor u_mon (.mclk(mclk), .rst_b(rst_b),
  .qpi_mode(qpi_mode), .nv_params(nv_params), .vol_params(vol_params), .sclk(sclk),
  .cs_b(cs_b), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .rd_byte(rd_byte),
  .rd_byte_take(rd_byte_take));
`default_nettype wire

// ===== rdc_host_model.sv
/*
 rdc_host_model: host controller owning sclk (12 ns, still between frames),
 cs_b and the data lines; supplies read bytes. assumes mode 0 clocking.
*/
`timescale 1ns/1ps
`default_nettype none
module rdc_host_model (
  output var logic sclk, // serial clock
  output var logic cs_b, // chip select, active low
  output var logic [3:0] io_in, // lines toward device
  output var logic [7:0] rd_byte, // read data source
  input wire logic rd_byte_take, // source advance
  input wire logic [3:0] io_out, // lines from device
  input wire logic [3:0] io_oe // device drive enables
);
  initial begin
    sclk = 1'b0;
    io_in = 4'h0;
    cs_b = 1'b0;
    #1 cs_b = 1'b1;
  end
  always @(posedge sclk or posedge cs_b) begin
    if (cs_b) begin
      rd_byte <= 8'ha5;
    end else if (rd_byte_take) begin
      rd_byte <= ~rd_byte;
    end
  end
  task automatic clk(input logic [3:0] v);
    #5 sclk = 1'b0;
    io_in = v;
    #6 sclk = 1'b1;
    #1;
  endtask : clk
  // oe_e: edge after opcode at which drive began, 0 if never
  task automatic frame(input logic [7:0] op, input bit q, input int al, input int ac,
    input logic [31:0] pay, input int dl, input int lim, output int oe_e, output logic [7:0] d);
    int k;
    oe_e = 0;
    d = 8'h00;
    k = 0;
    cs_b = 1'b0;
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      clk(q ? op[7-4*i -: 4] : {~io_in[3:1], op[7-i]});
    end
    for (int e = 1; e <= lim && k < 8; e++) begin
      if (e <= ac) begin
        case (al)
          1: clk({~io_in[3:1], pay[31]});
          2: clk({~io_in[3:2], pay[31:30]});
          default: clk(pay[31:28]);
        endcase
        pay = pay << al;
      end else begin
        clk(~io_in);
      end
      if (io_oe !== 4'h0 && oe_e == 0) begin
        oe_e = e;
      end
      if (oe_e != 0) begin
        case (dl)
          1: d = {d[6:0], io_out[1]};
          2: d = {d[5:0], io_out[1:0]};
          default: d = {d[3:0], io_out};
        endcase
        k = k + dl;
      end
    end
    #5 sclk = 1'b0;
    #3 cs_b = 1'b1;
    io_in = ~io_in;
    #30;
  endtask : frame
endmodule : rdc_host_model
`default_nettype wire

// ===== test_read_dummy_cycle_select.sv
/*
 test_read_dummy_cycle_select: scenario bench for the read dummy-cycle block.
 assumes the host model and the bound monitor.
*/
`timescale 1ns/1ps
`default_nettype none
module test_read_dummy_cycle_select;
  import rdc_pkg::*;
  logic mclk, rst_b, qpi_mode, sclk, cs_b, rd_byte_take;
  logic [7:0] nv_params, vol_params, rd_byte;
  logic [3:0] io_in, io_out, io_oe;
  int n_errors = 0;
  int check_count = 0;
  rdc_read_dummy_sel DUT (.mclk(mclk), .rst_b(rst_b), .qpi_mode(qpi_mode),
    .nv_params(nv_params), .vol_params(vol_params), .sclk(sclk), .cs_b(cs_b),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .rd_byte(rd_byte),
    .rd_byte_take(rd_byte_take));
  rdc_host_model u_host (.sclk(sclk), .cs_b(cs_b), .io_in(io_in), .rd_byte(rd_byte),
    .rd_byte_take(rd_byte_take), .io_out(io_out), .io_oe(io_oe));
  always #2.5 mclk = ~mclk;
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic rd(input logic [7:0] op, input bit q, input int al, input int ac,
    input int dl, input int want);
    int oe_e;
    logic [7:0] d;
    u_host.frame(op, q, al, ac, 32'h00123456, dl, want == 0 ? 40 : want + 10, oe_e, d);
    check(32'(oe_e), 32'(want));
    if (want != 0) begin
      check({24'h0, d}, 32'ha5);
    end
  endtask : rd
  task automatic setp(input logic [7:0] op, input logic [7:0] v, input bit q);
    int oe_e;
    logic [7:0] d;
    u_host.frame(op, q, q ? 4 : 1, q ? 2 : 8, {v, 24'h0}, 1, q ? 2 : 8, oe_e, d);
  endtask : setp
  task automatic wait_par(input logic [7:0] nv, input logic [7:0] vol);
    int i;
    for (i = 0; i < 40 && !(nv_params === nv && vol_params === vol); i++) begin
      @(negedge mclk);
    end
    if (i >= 40) begin
      n_errors++;
      finish_test();
    end
    check({24'h0, nv_params}, {24'h0, nv});
    check({24'h0, vol_params}, {24'h0, vol});
  endtask : wait_par
  task automatic set_qpi(input bit q);
    int oe_e;
    logic [7:0] d;
    @(posedge mclk);
    qpi_mode <= q;
    repeat (4) @(posedge mclk);
    u_host.frame(8'h00, 1'b0, 1, 0, 32'h0, 1, 4, oe_e, d);
  endtask : set_qpi
  task automatic t_reset();
    check({24'h0, nv_params}, 32'h0);
    check({24'h0, vol_params}, 32'h0);
    check({28'h0, io_oe}, 32'h0);
  endtask : t_reset
  task automatic t_spi_defaults();
    rd(OP_FAST_RD, 0, 1, 24, 1, 24 + DEF_FAST_SPI);
    rd(OP_FAST_RD4, 0, 1, 32, 1, 32 + DEF_FAST_SPI);
    rd(OP_FAST_DTR, 0, 1, 12, 1, 12 + DEF_FAST_SPI);
    rd(OP_UNIQUE_ID_READ, 0, 1, 24, 1, 24 + DEF_FAST_SPI);
    rd(OP_INFO_ROW_READ, 0, 1, 24, 1, 24 + DEF_FAST_SPI);
    rd(OP_DUAL_OUT, 0, 1, 24, 2, 24 + DEF_DUAL_OUT);
    rd(OP_DUAL_IO, 0, 2, 12, 2, 12 + 4 + DEF_DUAL_IO);
    rd(OP_DUAL_IO_DTR, 0, 2, 6, 2, 6 + 2 + DEF_DUAL_IO);
    rd(OP_QUAD_OUT, 0, 1, 24, 4, 24 + DEF_QUAD_OUT);
    rd(OP_QUAD_IO, 0, 4, 6, 4, 6 + 2 + DEF_QUAD_IO);
    rd(OP_QUAD_IO_DTR4, 0, 4, 4, 4, 4 + 1 + DEF_QUAD_IO);
    rd(OP_QUAD_IO_DTR, 0, 4, 3, 4, 3 + 1 + DEF_QUAD_IO);
    rd(OP_DUAL_OUT4, 0, 1, 32, 2, 32 + DEF_DUAL_OUT);
    rd(OP_DUAL_IO4, 0, 2, 16, 2, 16 + 4 + DEF_DUAL_IO);
    rd(OP_DUAL_IO_DTR4, 0, 2, 8, 2, 8 + 2 + DEF_DUAL_IO);
    rd(OP_QUAD_OUT4, 0, 1, 32, 4, 32 + DEF_QUAD_OUT);
  endtask : t_spi_defaults
  task automatic t_qpi_defaults();
    set_qpi(1'b1);
    rd(OP_FAST_RD, 1, 4, 6, 4, 6 + DEF_FAST_QPI);
    rd(OP_FAST_DTR, 1, 4, 3, 4, 3 + DEF_FAST_QPI);
    rd(OP_UNIQUE_ID_READ, 1, 4, 6, 4, 6 + DEF_FAST_QPI);
    rd(OP_INFO_ROW_READ, 1, 4, 6, 4, 6 + DEF_FAST_QPI);
    rd(OP_QUAD_IO, 1, 4, 6, 4, 6 + 2 + DEF_QUAD_IO);
    rd(OP_QUAD_IO_DTR, 1, 4, 3, 4, 3 + 1 + DEF_QUAD_IO);
    rd(OP_DUAL_IO_DTR, 1, 4, 2, 4, 0);
    rd(OP_DUAL_OUT, 1, 4, 6, 4, 0);
    rd(OP_QUAD_OUT, 1, 4, 6, 4, 0);
    set_qpi(1'b0);
  endtask : t_qpi_defaults
  task automatic t_field();
    setp(OP_SET_PARAMS_VOL_A, 8'h78, 1'b0);
    wait_par(8'h00, 8'h78);
    rd(OP_FAST_RD, 0, 1, 24, 1, 24 + 15);
    rd(OP_DUAL_IO, 0, 2, 12, 2, 12 + 4 + 15);
    setp(OP_SET_PARAMS_VOL_B, 8'h08, 1'b0);
    wait_par(8'h00, 8'h08);
    rd(OP_QUAD_IO, 0, 4, 6, 4, 6 + 2 + 1);
    rd(OP_QUAD_OUT, 0, 1, 24, 4, 24 + 1);
    set_qpi(1'b1);
    setp(OP_SET_PARAMS_VOL_A, 8'h70, 1'b1);
    wait_par(8'h00, 8'h70);
    rd(OP_FAST_RD, 1, 4, 6, 4, 6 + 14);
    set_qpi(1'b0);
    setp(OP_SET_PARAMS_PERSIST, 8'h28, 1'b0);
    wait_par(8'h28, 8'h70);
    setp(OP_SET_PARAMS_VOL_B, 8'h00, 1'b0);
    wait_par(8'h28, 8'h00);
    rd(OP_FAST_RD, 0, 1, 24, 1, 24 + DEF_FAST_SPI);
  endtask : t_field
  initial begin
    mclk = 1'b0;
    rst_b = 1'b1;
    qpi_mode = 1'b0;
    // a real falling edge, so async reset holds before the first mclk edge
    #1 rst_b = 1'b0;
    repeat (4) @(posedge mclk);
    t_reset();
    rst_b <= 1'b1;
    repeat (8) @(posedge mclk);
    t_spi_defaults();
    t_qpi_defaults();
    t_field();
    finish_test();
  end
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
endmodule : test_read_dummy_cycle_select
`default_nettype wire
